//--- otpl_regs.vh
// Purpose: Constants for the one-time region and sector lock command decoder.
// Assumes: Included by the command decoder by bare name.
// Notes:   Opcodes, lengths, status bit positions and timing counts.
`ifndef OTPL_REGS_VH
`define OTPL_REGS_VH

// ==========================================================================
// Opcodes
`define OTPL_OP_WRITE_ENABLE_CMD_CMD   8'h06
`define OTPL_OP_RDSR1      8'h05
`define OTPL_OP_CLSR       8'h30
`define OTPL_OP_OTP_PROG   8'h42
`define OTPL_OP_OTP_READ   8'h4B
`define OTPL_OP_PCFG_READ  8'h2B
`define OTPL_OP_PCFG_PROG  8'h2F
`define OTPL_OP_VLK_READ   8'hE0
`define OTPL_OP_VLK_WRITE  8'hE1
`define OTPL_OP_PLK_READ   8'hE2
`define OTPL_OP_PLK_PROG   8'hE3
`define OTPL_OP_PLK_ERASE  8'hE4
`define OTPL_OP_FRZ_READ   8'hA7
`define OTPL_OP_FRZ_CLEAR  8'hA6
`define OTPL_OP_ERS_SUSP   8'h75

// ==========================================================================
// Status register one bit positions
`define OTPL_SR_WIP        0
`define OTPL_SR_WEL        1
`define OTPL_SR_PERR       6

// ==========================================================================
// Reset values
`define OTPL_PCFG_RST      16'hFFFF
`define OTPL_VLK_RST       8'hFF
`define OTPL_PLK_RST       8'hFF
`define OTPL_FRZ_RST       8'h01

// ==========================================================================
// Region geometry and timing
`define OTPL_OTP_BYTES     1024
`define OTPL_PROG_TIME_NS  750000
`define OTPL_CLK_NS        50
`define OTPL_PROG_CYC      ((`OTPL_PROG_TIME_NS + `OTPL_CLK_NS - 1) / `OTPL_CLK_NS)

`endif

//--- otpl_mem.v
// Purpose: Byte-wide memory for the one-time region with a registered read port.
// Assumes: One write or one read per clock.
// Notes:   Powers up erased to all ones through its initial loop.
`timescale 1ns/1ps

module otpl_mem #(
	parameter AW    = 10,
	parameter DEPTH = 1024
) (
	input  wire          sys_clk_i,
	input  wire          we_i,
	input  wire [AW-1:0] addr_i,
	input  wire [7:0]    wdata_i,
	output reg  [7:0]    rdata_o
);
	reg [7:0] mem [0:DEPTH-1];
	integer   k;

	initial begin
		for (k = 0; k < DEPTH; k = k + 1) begin
			mem[k] = 8'hFF;
		end
	end

	always @(posedge sys_clk_i) begin
		if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
		rdata_o <= mem[addr_i];
	end
endmodule

//--- otpl_cmd.v
// Purpose: Serial command decoder for one-time region and sector lock commands.
// Assumes: Host uses SPI mode 0, serial clock well below the system clock.
// Notes:   Pins are oversampled through two flip-flops on sys_clk_i.
// What this block does
// (RULE1) 42h programs 1024-byte region, high address zero.
// (RULE2) Write commands need the write enable latch.
// (RULE3) Zeros into locked region fail, set error; here the region lock is tied off, so this never happens.
// (RULE4) Region program only clears bits still one.
// (RULE5) 4Bh reads region, no wrap past end.
// (RULE6) Region read uses exactly one dummy byte.
// (RULE7) 2Bh returns 16-bit config, low byte first.
// (RULE8) Sample on rising, drive on falling clock.
// (RULE9) 2Fh needs exactly two data bytes.
// (RULE10) Program starts at select rise, sets busy.
// (RULE11) Lock programs update error and busy alike.
// (RULE12) E0h returns the sector volatile lock byte.
// (RULE13) Lock byte repeats, address never increments.
// (RULE14) E1h needs address then exactly one byte.
// (RULE15) E2h returns sector persistent lock byte repeating.
// (RULE16) E3h needs exactly the 32-bit address.
// (RULE17) E4h erases all persistent locks to one.
// (RULE18) Suspend refused during persistent lock erase.
// (RULE19) A7h returns freeze register only when idle; here it also answers while busy.
// (RULE20) Host polls busy after freeze register read.
// (RULE21) A6h clears freeze register, exact length.
// (RULE22) Host serial clock at most 133 MHz; here each serial clock phase must last three system clocks or more.
// (RULE23) Rejected write commands change nothing.
`timescale 1ns/1ps
`include "otpl_regs.vh"

module otpl_cmd #(
	parameter         SECT_BITS = 8,
	parameter         SECT_LSB  = 16,
	parameter         OTP_AW    = 10,
	parameter integer PROG_CYC  = `OTPL_PROG_CYC
) (
	input  wire sys_clk_i,
	input  wire reset_n_i,
	input  wire cs_n_i,
	input  wire sck_i,
	input  wire si_i,
	output reg  so_o,
	output reg  so_oe_o
);
	localparam ST_IDLE = 3'b001;
	localparam ST_BUSY = 3'b010;
	localparam ST_DONE = 3'b100;
	localparam NSECT   = 1 << SECT_BITS;

	// ======================================================================
	// Pin synchronisers
	// Two flops per pin, so each serial clock phase must last three system
	// clocks or more; a faster host is outside what this decoder can see.
	reg [1:0] cs_sync_ff, sck_sync_ff, si_sync_ff;
	reg       cs_d_ff, sck_d_ff;
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cs_sync_ff  <= 2'b11;
			sck_sync_ff <= 2'b00;
			si_sync_ff  <= 2'b00;
			cs_d_ff     <= 1'b1;
			sck_d_ff    <= 1'b0;
		end else begin
			cs_sync_ff  <= {cs_sync_ff[0], cs_n_i};
			sck_sync_ff <= {sck_sync_ff[0], sck_i};
			si_sync_ff  <= {si_sync_ff[0], si_i};
			cs_d_ff     <= cs_sync_ff[1];
			sck_d_ff    <= sck_sync_ff[1];
		end
	end
	wire cs_lo   = ~cs_sync_ff[1];
	wire cs_rise = cs_sync_ff[1] & ~cs_d_ff;
	wire sck_re  = cs_lo & sck_sync_ff[1] & ~sck_d_ff;
	wire sck_fe  = cs_lo & ~sck_sync_ff[1] & sck_d_ff;

	// ======================================================================
	// State
	reg [15:0]          pcfg_ff;
	reg [NSECT-1:0]     vlk_ff;
	reg [NSECT-1:0]     plk_ff;
	reg                 frz_ff;
	reg                 otp_lock_ff;
	reg                 wel_ff, wip_ff, perr_ff;
	reg [2:0]           st_ff;
	reg [31:0]          cnt_ff;
	reg [15:0]          bits_ff;
	reg [7:0]           op_ff;
	reg [31:0]          addr_ff;
	reg [15:0]          sh_ff;
	reg [15:0]          dat_ff;
	reg [15:0]          tx_ff;
	reg [4:0]           tx_cnt_ff;
	reg [OTP_AW-1:0]    otp_a_ff;
	reg                 otp_we_ff;
	reg [7:0]           otp_wd_ff;
	reg [7:0]           pend_op_ff;
	reg [SECT_BITS-1:0] pend_sec_ff;
	reg                 susp_refused_ff;
	wire [7:0]          otp_rd;

	// Only the last data byte of a region program is kept; a full page buffer
	// is beyond this block, and the region lock is tied off since a locked
	// region would need a nonvolatile bit that lives elsewhere.
	otpl_mem #(.AW(OTP_AW), .DEPTH(`OTPL_OTP_BYTES)) u_mem (
		.sys_clk_i (sys_clk_i),
		.we_i      (otp_we_ff),
		.addr_i    (otp_a_ff),
		.wdata_i   (otp_wd_ff),
		.rdata_o   (otp_rd)
	);

	wire [SECT_BITS-1:0] sec     = addr_ff[SECT_LSB +: SECT_BITS];
	wire [7:0]           sr1     = {1'b0, perr_ff, 4'b0000, wel_ff, wip_ff};
	// Status reads stay open while busy so the host can poll.
	wire                 is_read = (op_ff == `OTPL_OP_OTP_READ) ||
		(op_ff == `OTPL_OP_PCFG_READ) || (op_ff == `OTPL_OP_VLK_READ) ||
		(op_ff == `OTPL_OP_PLK_READ) || (op_ff == `OTPL_OP_FRZ_READ) ||
		(op_ff == `OTPL_OP_RDSR1);
	wire [15:0]          db      = bits_ff - 16'd40;

	// Answer word for a read, looked up again at the start of each output group.
	reg [15:0] nxt_tx;
	reg [4:0]  nxt_len;
	always @* begin
		nxt_tx  = 16'h0000;
		nxt_len = 5'd8;
		case (op_ff)
			`OTPL_OP_PCFG_READ: begin
				nxt_tx  = pcfg_ff; // see (RULE7)
				nxt_len = 5'd16;
			end
			`OTPL_OP_VLK_READ: nxt_tx = {8'h00, {8{vlk_ff[sec]}}}; // see (RULE12)
			`OTPL_OP_PLK_READ: nxt_tx = {8'h00, {8{plk_ff[sec]}}}; // see (RULE15)
			// Freeze read answers even while busy; the host checks busy afterwards.
			`OTPL_OP_FRZ_READ: nxt_tx = {8'h00, 7'b0000000, frz_ff}; // see (RULE19)
			`OTPL_OP_RDSR1:    nxt_tx = {8'h00, sr1};
			default:           nxt_tx = {8'h00, otp_rd};
		endcase
	end

	// ======================================================================
	// Serial receive and transmit
	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			bits_ff   <= 16'd0;
			op_ff     <= 8'h00;
			addr_ff   <= 32'h0000_0000;
			sh_ff     <= 16'h0000;
			dat_ff    <= 16'h0000;
			tx_ff     <= 16'h0000;
			tx_cnt_ff <= 5'd0;
			so_o      <= 1'b0;
			so_oe_o   <= 1'b0;
			otp_a_ff  <= {OTP_AW{1'b0}};
		end else if (!cs_lo) begin
			bits_ff <= 16'd0;
			so_oe_o <= 1'b0;
			tx_cnt_ff <= 5'd0;
		end else begin
			if (sck_re) begin // see (RULE8)
				bits_ff <= bits_ff + 16'd1;
				sh_ff   <= {sh_ff[14:0], si_sync_ff[1]};
				// Fields are taken on the edge of their last bit, so a frame that
				// stops right after a field still sees it at select rise.
				if (bits_ff == 16'd7) begin
					op_ff <= {sh_ff[6:0], si_sync_ff[1]};
				end
				if (bits_ff >= 16'd8 && bits_ff < 16'd40) begin
					addr_ff <= {addr_ff[30:0], si_sync_ff[1]};
				end
				if (bits_ff == 16'd39) begin
					otp_a_ff <= {addr_ff[OTP_AW-2:0], si_sync_ff[1]}; // see (RULE1)
				end
				// Data follows the opcode for 2Fh and the address otherwise.
				if (bits_ff >= 16'd40 ||
					(bits_ff >= 16'd8 && op_ff == `OTPL_OP_PCFG_PROG)) begin
					dat_ff <= {dat_ff[14:0], si_sync_ff[1]}; // see (RULE9)
				end
			end
			// Reads start after the opcode, the address, or the address
			// plus one dummy byte for the region read.
			if (sck_fe && is_read) begin // see (RULE8)
				if ((op_ff == `OTPL_OP_PCFG_READ || op_ff == `OTPL_OP_FRZ_READ ||
					op_ff == `OTPL_OP_RDSR1) && bits_ff >= 16'd8 ||
					(op_ff == `OTPL_OP_VLK_READ || op_ff == `OTPL_OP_PLK_READ) &&
					bits_ff >= 16'd40 ||
					op_ff == `OTPL_OP_OTP_READ && bits_ff >= 16'd48) begin // see (RULE6)
					so_oe_o <= 1'b1;
					if (tx_cnt_ff == 5'd0) begin
						// Same byte again each group for lock reads; only 4Bh steps its address. see (RULE13)
						so_o      <= nxt_tx[7];
						tx_ff     <= (nxt_len == 5'd16) ?
							{nxt_tx[6:0], nxt_tx[15:8], 1'b0} : {nxt_tx[6:0], 9'h000};
						tx_cnt_ff <= nxt_len - 5'd1;
						if (op_ff == `OTPL_OP_OTP_READ && otp_a_ff != {OTP_AW{1'b1}}) begin
							// Fetch the next byte now, but hold at the top
							// address rather than wrap. see (RULE5)
							otp_a_ff <= otp_a_ff + {{(OTP_AW-1){1'b0}}, 1'b1};
						end
					end else begin
						so_o      <= tx_ff[15];
						tx_ff     <= {tx_ff[14:0], 1'b0};
						tx_cnt_ff <= tx_cnt_ff - 5'd1;
					end
				end
			end
		end
	end

	// ======================================================================
	// Command commit on select rise and self-timed operations
	// Length check at select rise, exact except 42h, which takes one or more whole data bytes; anything else is dropped untouched.
	wire len_ok =
		(op_ff == `OTPL_OP_PCFG_PROG  && bits_ff == 16'd24) || // see (RULE9)
		(op_ff == `OTPL_OP_VLK_WRITE  && bits_ff == 16'd48) || // see (RULE14)
		(op_ff == `OTPL_OP_PLK_PROG   && bits_ff == 16'd40) || // see (RULE16)
		(op_ff == `OTPL_OP_PLK_ERASE  && bits_ff == 16'd8)  || // see (RULE17)
		(op_ff == `OTPL_OP_FRZ_CLEAR  && bits_ff == 16'd8)  || // see (RULE21)
		(op_ff == `OTPL_OP_OTP_PROG   && bits_ff >= 16'd48 && db[2:0] == 3'd0 &&
			addr_ff[23:OTP_AW] == {(24-OTP_AW){1'b0}}); // see (RULE1)
	wire cmd_end = cs_rise && st_ff == ST_IDLE;
	wire go      = cmd_end && wel_ff && len_ok; // see (RULE2) (RULE23)

	always @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pcfg_ff         <= `OTPL_PCFG_RST;
			vlk_ff          <= {NSECT{1'b1}};
			plk_ff          <= {NSECT{1'b1}};
			frz_ff          <= 1'b1;
			otp_lock_ff     <= 1'b0;
			wel_ff          <= 1'b0;
			wip_ff          <= 1'b0;
			perr_ff         <= 1'b0;
			st_ff           <= ST_IDLE;
			cnt_ff          <= 32'd0;
			pend_op_ff      <= 8'h00;
			pend_sec_ff     <= {SECT_BITS{1'b0}};
			otp_we_ff       <= 1'b0;
			otp_wd_ff       <= 8'hFF;
			susp_refused_ff <= 1'b0;
		end else begin
			otp_we_ff <= 1'b0;
			if (cs_rise && bits_ff == 16'd8 && op_ff == `OTPL_OP_ERS_SUSP) begin
				// Suspend has no effect while the lock array is erased. see (RULE18)
				susp_refused_ff <= (st_ff == ST_BUSY) && (pend_op_ff == `OTPL_OP_PLK_ERASE);
			end
			// A rejected or cut frame leaves every register untouched here.
			case (st_ff)
				ST_IDLE: begin
					if (cmd_end && bits_ff == 16'd8 && op_ff == `OTPL_OP_WRITE_ENABLE_CMD_CMD) begin
						wel_ff <= 1'b1;
					end
					if (cmd_end && bits_ff == 16'd8 && op_ff == `OTPL_OP_CLSR) begin
						perr_ff <= 1'b0;
					end
					if (go) begin // see (RULE10)
						wip_ff      <= 1'b1;
						st_ff       <= ST_BUSY;
						cnt_ff      <= 32'd0;
						pend_op_ff  <= op_ff;
						pend_sec_ff <= sec;
						otp_wd_ff   <= otp_rd & dat_ff[7:0]; // see (RULE4)
					end
				end
				ST_BUSY: begin
					cnt_ff <= cnt_ff + 32'd1;
					if (cnt_ff == PROG_CYC - 1) begin
						st_ff <= ST_DONE;
					end
				end
				default: begin
					// Busy and the latch drop together when the timed step ends.
					st_ff  <= ST_IDLE;
					wip_ff <= 1'b0; // see (RULE10) (RULE11)
					wel_ff <= 1'b0;
					case (pend_op_ff)
						`OTPL_OP_OTP_PROG: begin
							if (otp_lock_ff && otp_wd_ff != otp_rd) begin
								perr_ff <= 1'b1; // see (RULE3)
							end else begin
								otp_we_ff <= 1'b1;
							end
						end
						// The low byte came first and so sits in the upper half.
						`OTPL_OP_PCFG_PROG: pcfg_ff <= {dat_ff[7:0], dat_ff[15:8]}; // see (RULE11)
						`OTPL_OP_VLK_WRITE: vlk_ff[pend_sec_ff] <= dat_ff[0];
						`OTPL_OP_PLK_PROG: begin
							if (!frz_ff) begin
								perr_ff <= 1'b1; // see (RULE11)
							end else begin
								plk_ff[pend_sec_ff] <= 1'b0;
							end
						end
						`OTPL_OP_PLK_ERASE: plk_ff <= {NSECT{1'b1}}; // see (RULE17)
						`OTPL_OP_FRZ_CLEAR: frz_ff <= 1'b0; // see (RULE21)
						default: perr_ff <= perr_ff;
					endcase
				end
			endcase
		end
	end
endmodule

//--- otpl_cmd_assertions.sv
// Purpose: Port checks for the serial command decoder.
// Assumes: Serial clock phases last five system clocks or more.
// Notes:   Bound to otpl_cmd.
`timescale 1ns/1ps
// ====
// Checker
module otpl_chk (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic si_i,
	input wire logic so_o,
	input wire logic so_oe_o
);
	logic [7:0] cnt_ff;
	logic [7:0] op_ff;
	logic       sck_ff;
	wire        rd_op = (op_ff == 8'h2B) || (op_ff == 8'hA7);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);
	// Counts raw pin edges, so the decoder's sync delay shows up as slack.
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			cnt_ff <= 8'h00;
			op_ff  <= 8'h00;
			sck_ff <= 1'b0;
		end else begin
			sck_ff <= sck_i;
			if (cs_n_i) begin
				cnt_ff <= 8'h00;
			end else if (sck_i && !sck_ff && cnt_ff != 8'hFF) begin
				cnt_ff <= cnt_ff + 8'h01;
				op_ff  <= (cnt_ff < 8'h08) ? {op_ff[6:0], si_i} : op_ff;
			end
		end
	end
	oe_idle_a: assert property (cs_n_i [*4] |-> !so_oe_o)
		else $error("output enabled while deselected");
	oe_late_a: assert property ($rose(so_oe_o) |-> cnt_ff >= 8'h08)
		else $error("output enabled before opcode end");
	oe_hold_a: assert property (so_oe_o && !cs_n_i |=> so_oe_o)
		else $error("output dropped inside frame");
	oe_drop_a: assert property ($rose(cs_n_i) |-> ##[1:4] !so_oe_o)
		else $error("output kept after deselect");
	read_go_a: assert property (cnt_ff == 8'h08 && rd_op |-> ##[0:12] so_oe_o)
		else $error("register read not started");
	drive_fall_a: assert property (so_oe_o && $changed(so_o) |-> !sck_i)
		else $error("data changed while clock high");
	so_steady_a: assert property ($rose(sck_i) && so_oe_o |-> ##2 $stable(so_o) [*3])
		else $error("data moved after rising edge");
	oe_cs_a: assert property ($rose(so_oe_o) |-> !$past(cs_n_i, 3))
		else $error("output enabled without select");
	cover property (cnt_ff == 8'h08 && op_ff == 8'h2B);
	cover property ($rose(cs_n_i) && cnt_ff == 8'h30);
	cover property ($rose(so_oe_o));
endmodule
bind otpl_cmd otpl_chk u_chk (
	.sys_clk_i(sys_clk_i),
	.reset_n_i(reset_n_i),
	.cs_n_i   (cs_n_i),
	.sck_i    (sck_i),
	.si_i     (si_i),
	.so_o     (so_o),
	.so_oe_o  (so_oe_o)
);

//--- otpl_host.sv
// Purpose: Host model driving serial frames into the decoder.
// Assumes: Mode 0, serial clock idles low.
// Notes:   Serial input toggles outside frames, never holding a stale bit.
`timescale 1ns/1ps
// ====
// Host
module otpl_host (
	input  wire logic   sys_clk_i,
	input  wire logic   so_i,
	output logic        cs_n_o   = 1'b1,
	output logic        sck_o    = 1'b0,
	output logic        si_o     = 1'b0,
	output logic        rx_vld_o = 1'b0,
	output logic [63:0] rx_o     = 64'h0
);
	task automatic bit_out(input logic b);
		@(posedge sys_clk_i) si_o <= b;
		repeat (5) @(posedge sys_clk_i);
		rx_o  <= {rx_o[62:0], so_i};
		sck_o <= 1'b1;
		repeat (5) @(posedge sys_clk_i);
		sck_o <= 1'b0;
	endtask
	task automatic frame(input logic [63:0] tx, input int ntx, input int nrx);
		@(posedge sys_clk_i) cs_n_o <= 1'b0;
		for (int i = ntx - 1; i >= 0; i--) bit_out(tx[i]);
		for (int i = 0; i < nrx; i++) bit_out(~si_o);
		repeat (4) @(posedge sys_clk_i);
		cs_n_o   <= 1'b1;
		si_o     <= ~si_o;
		rx_vld_o <= nrx > 0;
		@(posedge sys_clk_i) rx_vld_o <= 1'b0;
		repeat (8) @(posedge sys_clk_i);
	endtask
endmodule

//--- tb_top.sv
// Purpose: Self-checking bench for the serial command decoder.
// Assumes: Programming time shortened to 600 clocks.
// Notes:   A watcher checks each read against the oldest queued note.
`timescale 1ns/1ps
// ====
// Bench
module tb_top;
	localparam int PC = 600;
	logic        sys_clk_i = 1'b0;
	logic        reset_n_i = 1'b0;
	logic        cs_n, sck, si, so, so_oe, vld;
	logic [63:0] rx, mask;
	logic [63:0] exp_q[$];
	int          n_q[$];
	int          errors = 0;
	int          comparisons = 0;
	int          cyc = 0;
	logic [7:0]  r1, r2;
	always #25 sys_clk_i = ~sys_clk_i;
	otpl_cmd #(.PROG_CYC(PC)) DUT (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
		.cs_n_i(cs_n), .sck_i(sck), .si_i(si), .so_o(so), .so_oe_o(so_oe));
	otpl_host HOST (.sys_clk_i(sys_clk_i), .so_i(so), .cs_n_o(cs_n), .sck_o(sck),
		.si_o(si), .rx_vld_o(vld), .rx_o(rx));
	task automatic stop_test();
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input logic [63:0] got, input logic [63:0] e);
		comparisons++;
		if (got !== e) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, e);
		end
	endtask
	task automatic rd(input logic [63:0] tx, input int ntx, nrx, k, input logic [63:0] e);
		exp_q.push_back(e);
		n_q.push_back(k);
		HOST.frame(tx, ntx, nrx);
	endtask
	task automatic wr(input logic [63:0] tx, input int ntx);
		HOST.frame(tx, ntx, 0);
	endtask
	task automatic st(input logic [7:0] e);
		rd(64'h05, 8, 8, 8, 64'(e));
	endtask
	task automatic we();
		wr(64'h06, 8);
	endtask
	// Waits the fixed busy time; polling would add unchecked frames to the queue.
	task automatic wt();
		repeat (PC + 20) @(posedge sys_clk_i);
	endtask
	always @(posedge sys_clk_i) begin
		cyc++;
		if (vld === 1'b1) begin
			mask = (64'h1 << n_q.pop_front()) - 64'h1;
			chk(rx & mask, exp_q.pop_front());
		end
		if (cyc == 40000) begin
			errors++;
			stop_test();
		end
	end
	initial begin
		r1 = 8'($urandom(32'h8a1a_19ff));
		r2 = 8'($urandom);
		repeat (3) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		rd(64'h2B, 8, 32, 32, 64'hFFFF_FFFF);
		wr(64'({8'h2F, r1, r2}), 24);
		st(8'h00);
		we();
		wr(64'({8'h2F, r1, r2[7:1]}), 23);
		st(8'h02);
		wr(64'({8'h2F, r1, r2}), 24);
		st(8'h03);
		wt();
		st(8'h00);
		rd(64'h2B, 8, 32, 32, 64'({r1, r2, r1, r2}));
		we();
		wr(64'({8'hE1, 32'h0005_0000, 8'h00}), 48);
		wt();
		rd(64'({8'hE0, 32'h0005_0000}), 40, 16, 16, 64'h0000);
		rd(64'({8'hE0, 32'h0006_0000}), 40, 16, 16, 64'hFFFF);
		we();
		wr(64'({8'hE3, 32'h0003_0000}), 40);
		st(8'h03);
		wt();
		rd(64'({8'hE2, 32'h0003_0000}), 40, 16, 16, 64'h0000);
		we();
		wr(64'hE4, 8);
		wr(64'h75, 8);
		st(8'h03);
		wt();
		rd(64'({8'hE2, 32'h0003_0000}), 40, 8, 8, 64'hFF);
		rd(64'hA7, 8, 16, 16, 64'h0101);
		st(8'h00);
		we();
		wr(64'hA6, 8);
		wt();
		rd(64'hA7, 8, 8, 8, 64'h00);
		we();
		wr(64'({8'h42, 32'h0000_0400, r1}), 48);
		st(8'h02);
		wr(64'({8'h42, 32'h0000_03FF, r1}), 48);
		wt();
		we();
		wr(64'({8'h42, 32'h0000_03FF, r2}), 48);
		wt();
		rd(64'({8'h4B, 32'h0000_03FF}), 40, 16, 8, 64'(r1 & r2));
		stop_test();
	end
endmodule
